// ===== src/pvs_pkg.sv
package pvs_pkg;

  // ************************************************************
  // Register offsets and field positions
  // ************************************************************
  localparam logic [4:0] NEGOTIATED_MODE_STATUS_OFS = 5'h11;
  localparam logic [4:0] TEN_MBPS_CONFIG_STATUS_OFS = 5'h12;

  localparam int RES_FAST_FULL_BIT = 15;
  localparam int RES_FAST_HALF_BIT = 14;
  localparam int RES_SLOW_FULL_BIT = 13;
  localparam int RES_SLOW_HALF_BIT = 12;
  localparam int ADDR_MSB          = 8;
  localparam int ADDR_LSB          = 4;
  localparam int MON_MSB           = 3;
  localparam int MON_LSB           = 0;

  localparam int LINK_PULSE_BIT    = 14;
  localparam int HEARTBEAT_BIT     = 13;
  localparam int SQUELCH_BIT       = 12;
  localparam int JABBER_BIT        = 11;
  localparam int RSVD_RW_BIT       = 10;
  localparam int POLARITY_BIT      = 0;

  localparam int ADDR_WIDTH        = 5;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [3:0] RESULT_RESET     = 4'hF;
  localparam logic       LINK_PULSE_RESET = 1'h1;
  localparam logic       HEARTBEAT_RESET  = 1'h1;
  localparam logic       SQUELCH_RESET    = 1'h1;
  localparam logic       JABBER_RESET     = 1'h1;
  localparam logic       RSVD_RW_RESET    = 1'h0;
  localparam logic       POLARITY_RESET   = 1'h0;

  // ************************************************************
  // Negotiation monitor codes
  // ************************************************************
  typedef enum logic [3:0] {
    PVS_MON_IDLE         = 4'h0,
    PVS_MON_ABILITY      = 4'h1,
    PVS_MON_ACK          = 4'h2,
    PVS_MON_ACK_FAIL     = 4'h3,
    PVS_MON_CONSIST      = 4'h4,
    PVS_MON_CONSIST_FAIL = 4'h5,
    PVS_MON_PD_READY     = 4'h6,
    PVS_MON_PD_FAIL      = 4'h7,
    PVS_MON_COMPLETE     = 4'h8
  } pvs_mon_type;

  localparam pvs_mon_type MON_RESET = PVS_MON_IDLE;

  // ************************************************************
  // Address matcher states
  // ************************************************************
  typedef enum logic [1:0] {
    PVS_MT_IDLE  = 2'h0,
    PVS_MT_SHIFT = 2'h1,
    PVS_MT_DONE  = 2'h3
  } pvs_mt_state_type;

  localparam logic [2:0] ADDR_LAST_IDX = 3'h4;

endpackage

// ===== src/pvs_match_if.sv
`timescale 1ns/100ps
`default_nettype none

interface pvs_match_if;
  logic       frame_start;
  logic       addr_bit;
  logic       addr_bit_valid;
  logic [4:0] station_addr;
  logic       addr_match;
  logic       addr_done;

  modport regs (
    output frame_start,
    output addr_bit,
    output addr_bit_valid,
    output station_addr,
    input  addr_match,
    input  addr_done
  );

  modport matcher (
    input  frame_start,
    input  addr_bit,
    input  addr_bit_valid,
    input  station_addr,
    output addr_match,
    output addr_done
  );
endinterface

`default_nettype wire

// ===== src/pvs_addr_match.sv
`timescale 1ns/100ps
`default_nettype none

module pvs_addr_match
  import pvs_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  pvs_match_if.matcher    mif
);

  // ************************************************************
  // Serial address compare, most significant bit first
  // ************************************************************
  pvs_mt_state_type state;
  pvs_mt_state_type next_state;
  logic [2:0]       idx;
  logic             mismatch;
  logic             match;
  logic             done;

  wire logic       take_bit = (state == PVS_MT_SHIFT) && mif.addr_bit_valid;
  wire logic [2:0] bit_pos  = ADDR_LAST_IDX - idx;
  wire logic       bit_ok   = (mif.addr_bit == mif.station_addr[bit_pos]);
  wire logic       last_bit = (idx == ADDR_LAST_IDX);

  always_comb begin
    next_state = state;
    unique case (state)
      PVS_MT_IDLE: begin
        if (mif.frame_start) begin
          next_state = PVS_MT_SHIFT;
        end
      end
      PVS_MT_SHIFT: begin
        if (mif.frame_start) begin
          next_state = PVS_MT_SHIFT;
        end else if (take_bit && last_bit) begin
          next_state = PVS_MT_DONE;
        end
      end
      PVS_MT_DONE: begin
        if (mif.frame_start) begin
          next_state = PVS_MT_SHIFT;
        end
      end
      default: begin
        next_state = PVS_MT_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state    <= PVS_MT_IDLE;
      idx      <= 3'h0;
      mismatch <= 1'b0;
      match    <= 1'b0;
      done     <= 1'b0;
    end else begin
      state <= next_state;
      done  <= take_bit && last_bit;
      if (mif.frame_start) begin
        idx      <= 3'h0;
        mismatch <= 1'b0;
        match    <= 1'b0;
      end else if (take_bit) begin
        idx      <= idx + 3'h1;
        mismatch <= mismatch | ~bit_ok;
        match    <= last_bit & ~(mismatch | ~bit_ok);
      end
    end
  end

  assign mif.addr_match = match;
  assign mif.addr_done  = done;

endmodule

`default_nettype wire

// ===== src/pvs_regs.sv
// How it works
// - A completed negotiation sets exactly one of four result bits 15..12, which reset to all ones.
// - The result bits mean nothing outside auto-negotiation mode and a valid flag says when to use them.
// - Reserved bits read as zero and writes to them are dropped, except config bit 10, which keeps and reads back the value written.
// - The station address is compared against the frame most significant bit first.
// - Bits 3..0 report the negotiation state codes 0 to 5 and reset to zero.
// - The monitor also reports 6, 7 for parallel detection and 8 for successful completion.
// - Link pulse enable resets to one, sends pulses when set and forces link good when clear, at 10 Mbps only.
// - Heartbeat enable resets to one and acts only at 10 Mbps half duplex.
// - Jabber enable resets to one and acts at 10 Mbps full duplex or 10 Mbps loop-back.
// - Polarity reversed follows the 10 Mbps receive logic and resets to zero.
// - A latching-high bit would clear when its register is read.
`timescale 1ns/100ps
`default_nettype none

module pvs_regs
  import pvs_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic [4:0]  strap_addr_in,
  input  wire logic [4:0]  reg_addr_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  input  wire logic [15:0] reg_wdata_in,
  output logic [15:0]      reg_rdata_out,
  output logic             reg_rvalid_out,
  input  wire logic        frame_start_in,
  input  wire logic        frame_addr_bit_in,
  input  wire logic        frame_addr_valid_in,
  output logic             addr_match_out,
  output logic             addr_done_out,
  input  wire logic        an_mode_in,
  input  wire logic        an_complete_in,
  input  wire logic        an_speed_100_in,
  input  wire logic        an_full_duplex_in,
  input  wire logic [3:0]  an_monitor_in,
  input  wire logic        speed_10_in,
  input  wire logic        full_duplex_in,
  input  wire logic        loopback_in,
  input  wire logic        polarity_reversed_in,
  output logic             result_valid_out,
  output logic             link_pulse_enable_out,
  output logic             force_link_good_out,
  output logic             heartbeat_active_out,
  output logic             squelch_normal_out,
  output logic             jabber_active_out,
  output logic [4:0]       mgmt_station_addr_out
);

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic mon_legal(input logic [3:0] code);
    mon_legal = (code <= 4'(PVS_MON_COMPLETE));
  endfunction

  function automatic logic [3:0] result_onehot(input logic fast, input logic full);
    logic [3:0] r;
    r = 4'h0;
    unique case ({fast, full})
      2'b11: r[RES_FAST_FULL_BIT - RES_SLOW_HALF_BIT] = 1'b1;
      2'b10: r[RES_FAST_HALF_BIT - RES_SLOW_HALF_BIT] = 1'b1;
      2'b01: r[RES_SLOW_FULL_BIT - RES_SLOW_HALF_BIT] = 1'b1;
      2'b00: r[0] = 1'b1;
    endcase
    result_onehot = r;
  endfunction

  // ************************************************************
  // Storage
  // ************************************************************
  logic [3:0]           neg_result;
  pvs_mon_type          negotiation_monitor_code;
  logic [4:0]           mgmt_station_addr;
  logic                 strap_taken;
  logic                 link_pulse_enable;
  logic                 heartbeat_enable;
  logic                 squelch_enable;
  logic                 jabber_enable;
  logic                 rsvd_rw;
  logic                 polarity_reversed;
  logic [15:0]          rdata;
  logic                 rvalid;

  wire logic sel_status = (reg_addr_in == NEGOTIATED_MODE_STATUS_OFS);
  wire logic sel_config = (reg_addr_in == TEN_MBPS_CONFIG_STATUS_OFS);
  wire logic wr_status  = reg_wr_in && sel_status;
  wire logic wr_config  = reg_wr_in && sel_config;

  // ************************************************************
  // Read images
  // ************************************************************
  logic [15:0] status_image;
  logic [15:0] config_image;

  always_comb begin
    status_image = 16'h0000;
    status_image[RES_FAST_FULL_BIT:RES_SLOW_HALF_BIT] = neg_result;
    status_image[ADDR_MSB:ADDR_LSB] = mgmt_station_addr;
    status_image[MON_MSB:MON_LSB] = negotiation_monitor_code;
  end

  always_comb begin
    config_image = 16'h0000;
    config_image[LINK_PULSE_BIT] = link_pulse_enable;
    config_image[HEARTBEAT_BIT]  = heartbeat_enable;
    config_image[SQUELCH_BIT]    = squelch_enable;
    config_image[JABBER_BIT]     = jabber_enable;
    config_image[RSVD_RW_BIT]    = rsvd_rw;
    config_image[POLARITY_BIT]   = polarity_reversed;
  end

  // Reading has no side effect: neither register holds a latching-high bit.
  wire logic [15:0] next_rdata = sel_status ? status_image :
                                 sel_config ? config_image : 16'h0000;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata  <= 16'h0000;
      rvalid <= 1'b0;
    end else begin
      rvalid <= reg_rd_in;
      if (reg_rd_in) begin
        rdata <= next_rdata;
      end
    end
  end

  // ************************************************************
  // Negotiation result and monitor
  // ************************************************************
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      neg_result               <= RESULT_RESET;
      negotiation_monitor_code <= MON_RESET;
    end else begin
      if (an_complete_in) begin
        neg_result <= result_onehot(an_speed_100_in, an_full_duplex_in);
      end
      if (mon_legal(an_monitor_in)) begin
        negotiation_monitor_code <= pvs_mon_type'(an_monitor_in);
      end
    end
  end

  // ************************************************************
  // Station address
  // ************************************************************
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      strap_taken       <= 1'b0;
      mgmt_station_addr <= 5'h00;
    end else begin
      strap_taken <= 1'b1;
      if (!strap_taken) begin
        mgmt_station_addr <= strap_addr_in;
      end else if (wr_status) begin
        mgmt_station_addr <= reg_wdata_in[ADDR_MSB:ADDR_LSB];
      end
    end
  end

  // ************************************************************
  // 10 Mbps configuration
  // ************************************************************
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      link_pulse_enable <= LINK_PULSE_RESET;
      heartbeat_enable  <= HEARTBEAT_RESET;
      squelch_enable    <= SQUELCH_RESET;
      jabber_enable     <= JABBER_RESET;
      rsvd_rw           <= RSVD_RW_RESET;
      polarity_reversed <= POLARITY_RESET;
    end else begin
      polarity_reversed <= polarity_reversed_in;
      if (wr_config) begin
        link_pulse_enable <= reg_wdata_in[LINK_PULSE_BIT];
        heartbeat_enable  <= reg_wdata_in[HEARTBEAT_BIT];
        squelch_enable    <= reg_wdata_in[SQUELCH_BIT];
        jabber_enable     <= reg_wdata_in[JABBER_BIT];
        rsvd_rw           <= reg_wdata_in[RSVD_RW_BIT];
      end
    end
  end

  // ************************************************************
  // Address matcher
  // ************************************************************
  pvs_match_if mif ();

  assign mif.frame_start    = frame_start_in;
  assign mif.addr_bit       = frame_addr_bit_in;
  assign mif.addr_bit_valid = frame_addr_valid_in;
  assign mif.station_addr   = mgmt_station_addr;

  pvs_addr_match u_match (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .mif      (mif.matcher)
  );

  // ************************************************************
  // Outputs
  // ************************************************************
  assign reg_rdata_out         = rdata;
  assign reg_rvalid_out        = rvalid;
  assign addr_match_out        = mif.addr_match;
  assign addr_done_out         = mif.addr_done;
  assign result_valid_out      = an_mode_in;
  assign mgmt_station_addr_out = mgmt_station_addr;
  assign link_pulse_enable_out = link_pulse_enable & speed_10_in;
  assign force_link_good_out   = ~link_pulse_enable & speed_10_in;
  assign heartbeat_active_out  = heartbeat_enable & speed_10_in & ~full_duplex_in;
  assign squelch_normal_out    = squelch_enable;
  assign jabber_active_out     = jabber_enable & speed_10_in
                                 & (full_duplex_in | loopback_in);

endmodule

`default_nettype wire

// ===== tb/pvs_regs_sva.sv
`timescale 1ns/100ps
`default_nettype none

module pvs_regs_sva
  import pvs_pkg::*;
(
  input wire logic        clk_in,
  input wire logic        rst_n_in,
  input wire logic [4:0]  reg_addr_in,
  input wire logic        reg_rd_in,
  input wire logic [15:0] reg_rdata_out,
  input wire logic        reg_rvalid_out,
  input wire logic        frame_start_in,
  input wire logic        addr_match_out,
  input wire logic        addr_done_out,
  input wire logic        an_mode_in,
  input wire logic        an_complete_in,
  input wire logic        an_speed_100_in,
  input wire logic        an_full_duplex_in,
  input wire logic [3:0]  an_monitor_in,
  input wire logic        speed_10_in,
  input wire logic        full_duplex_in,
  input wire logic        loopback_in,
  input wire logic        polarity_reversed_in,
  input wire logic        result_valid_out,
  input wire logic        link_pulse_enable_out,
  input wire logic        force_link_good_out,
  input wire logic        heartbeat_active_out,
  input wire logic        jabber_active_out,
  input wire logic [4:0]  mgmt_station_addr_out
);
  // ****************
  // Properties
  // ****************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_rd(logic [4:0] a);
    reg_rd_in && reg_addr_in == a;
  endsequence
  // A completion, one quiet cycle, then a status read: the read sees that completion.
  sequence s_done;
    an_complete_in ##1 !an_complete_in ##1 s_rd(NEGOTIATED_MODE_STATUS_OFS);
  endsequence

  property p_rvalid;
    reg_rd_in |=> reg_rvalid_out;
  endproperty
  property p_stat;
    s_rd(NEGOTIATED_MODE_STATUS_OFS) |=>
      reg_rdata_out[11:9] == 3'h0 && reg_rdata_out[8:4] == $past(mgmt_station_addr_out);
  endproperty
  property p_cfg;
    s_rd(TEN_MBPS_CONFIG_STATUS_OFS) |=> reg_rdata_out[15] == 1'h0 &&
      reg_rdata_out[9:1] == 9'h000 && reg_rdata_out[0] == $past(polarity_reversed_in, 2);
  endproperty
  property p_onehot;
    s_done |=> $onehot(reg_rdata_out[15:12]) &&
      reg_rdata_out[15] == $past(an_speed_100_in && an_full_duplex_in, 3);
  endproperty
  property p_mon;
    s_rd(NEGOTIATED_MODE_STATUS_OFS) and $past(an_monitor_in) <= 4'h8 |=>
      reg_rdata_out[3:0] == $past(an_monitor_in, 2);
  endproperty
  property p_unmapped;
    reg_rd_in && reg_addr_in != 5'h11 && reg_addr_in != 5'h12 |=> reg_rdata_out == 16'h0000;
  endproperty
  property p_valid;
    result_valid_out == an_mode_in;
  endproperty
  property p_link;
    (link_pulse_enable_out || force_link_good_out) == speed_10_in &&
      !(link_pulse_enable_out && force_link_good_out);
  endproperty
  property p_hb;
    heartbeat_active_out |-> speed_10_in && !full_duplex_in;
  endproperty
  property p_jab;
    jabber_active_out |-> speed_10_in && (full_duplex_in || loopback_in);
  endproperty
  property p_done;
    addr_done_out |=> !addr_done_out;
  endproperty
  property p_match;
    frame_start_in |=> !addr_match_out;
  endproperty

  a_rvalid: assert property (p_rvalid)
    else $error("read valid missing");
  a_stat: assert property (p_stat)
    else $error("status reserved or address field wrong");
  a_cfg: assert property (p_cfg)
    else $error("config reserved or polarity wrong");
  a_onehot: assert property (p_onehot)
    else $error("result bits not one-hot");
  a_mon: assert property (p_mon)
    else $error("monitor code wrong");
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  a_valid: assert property (p_valid)
    else $error("result valid wrong");
  a_link: assert property (p_link)
    else $error("link pulse gating wrong");
  a_hb: assert property (p_hb)
    else $error("heartbeat gating wrong");
  a_jab: assert property (p_jab)
    else $error("jabber gating wrong");
  a_done: assert property (p_done)
    else $error("done not a pulse");
  a_match: assert property (p_match)
    else $error("match not cleared");
endmodule

bind pvs_regs pvs_regs_sva pvs_regs_sva_i (.clk_in, .rst_n_in, .reg_addr_in, .reg_rd_in,
  .reg_rdata_out, .reg_rvalid_out, .frame_start_in, .addr_match_out, .addr_done_out,
  .an_mode_in, .an_complete_in, .an_speed_100_in, .an_full_duplex_in, .an_monitor_in,
  .speed_10_in, .full_duplex_in, .loopback_in, .polarity_reversed_in, .result_valid_out,
  .link_pulse_enable_out, .force_link_good_out, .heartbeat_active_out, .jabber_active_out,
  .mgmt_station_addr_out);

`default_nettype wire

// ===== tb/pvs_mgmt_model.sv
`timescale 1ns/100ps
`default_nettype none

module pvs_mgmt_model (
  input  wire logic        clk_in,
  input  wire logic [15:0] rdata_in,
  input  wire logic        rvalid_in,
  input  wire logic        done_in,
  input  wire logic        match_in,
  output logic [4:0]       addr_out = 5'h00,
  output logic             wr_out = 1'b0,
  output logic             rd_out = 1'b0,
  output logic [15:0]      wdata_out = 16'h0000,
  output logic             start_out = 1'b0,
  output logic             bit_out = 1'b0,
  output logic             bit_valid_out = 1'b0
);
  // ****************
  // Access tasks
  // ****************
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge clk_in);
    addr_out = a;
    wdata_out = d & 16'hFBFF;
    wr_out = 1'b1;
    @(negedge clk_in);
    wr_out = 1'b0;
    wdata_out = ~wdata_out;
  endtask

  task automatic rd(input logic [4:0] a, output logic [15:0] d, output logic ok);
    @(negedge clk_in);
    addr_out = a;
    rd_out = 1'b1;
    @(negedge clk_in);
    rd_out = 1'b0;
    ok = 1'b0;
    d = 16'h0000;
    for (int i = 0; i < 4 && !ok; i++) begin
      if (rvalid_in === 1'b1) begin
        ok = 1'b1;
        d = rdata_in;
      end
      else
        @(negedge clk_in);
    end
  endtask

  // Targets one station by its address, sent most significant bit first.
  task automatic send(input logic [4:0] a, output logic done, output logic match);
    @(negedge clk_in);
    start_out = 1'b1;
    @(negedge clk_in);
    start_out = 1'b0;
    for (int i = 4; i >= 0; i--) begin
      bit_out = a[i];
      bit_valid_out = 1'b1;
      @(negedge clk_in);
    end
    bit_valid_out = 1'b0;
    bit_out = ~bit_out;
    done = 1'b0;
    match = 1'b0;
    for (int i = 0; i < 3 && !done; i++) begin
      if (done_in === 1'b1) begin
        done = 1'b1;
        match = match_in;
      end
      else
        @(negedge clk_in);
    end
  endtask
endmodule

`default_nettype wire

// ===== tb/pvs_regs_tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module pvs_regs_tb_top;
  import pvs_pkg::*;
  localparam logic [4:0] ST = NEGOTIATED_MODE_STATUS_OFS;
  localparam logic [4:0] CF = TEN_MBPS_CONFIG_STATUS_OFS;
  logic clk_in = 1'b0, rst_n_in = 1'b0, an_mode_in = 1'b0, an_complete_in = 1'b0;
  logic an_speed_100_in = 1'b0, an_full_duplex_in = 1'b0, speed_10_in = 1'b1;
  logic full_duplex_in = 1'b0, loopback_in = 1'b0, polarity_reversed_in = 1'b0;
  logic [3:0] an_monitor_in = 4'h0;
  logic [4:0] strap_addr_in = 5'h15, reg_addr_in, mgmt_station_addr_out;
  logic [15:0] reg_wdata_in, reg_rdata_out;
  logic reg_wr_in, reg_rd_in, reg_rvalid_out, frame_start_in, frame_addr_bit_in;
  logic frame_addr_valid_in, addr_match_out, addr_done_out, result_valid_out;
  logic link_pulse_enable_out, force_link_good_out, heartbeat_active_out;
  logic squelch_normal_out, jabber_active_out, dn, mt;
  int num_errors = 0;
  int checked = 0;

  always #10 clk_in = ~clk_in;

  pvs_regs pvs_regs_i (.*);
  pvs_mgmt_model pvs_mgmt_model_i (.clk_in, .rdata_in(reg_rdata_out),
    .rvalid_in(reg_rvalid_out), .done_in(addr_done_out), .match_in(addr_match_out),
    .addr_out(reg_addr_in), .wr_out(reg_wr_in), .rd_out(reg_rd_in),
    .wdata_out(reg_wdata_in), .start_out(frame_start_in), .bit_out(frame_addr_bit_in),
    .bit_valid_out(frame_addr_valid_in));

  // ****************
  // Checking tasks
  // ****************
  task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic rdc(input logic [4:0] a, input logic [15:0] exp);
    logic [15:0] d;
    logic ok;
    pvs_mgmt_model_i.rd(a, d, ok);
    chk("read valid", ok, 1'b1);
    if (!ok)
      finish_test();
    chk("read data", d, exp);
  endtask

  task automatic frame(input logic [4:0] a, input logic exp);
    pvs_mgmt_model_i.send(a, dn, mt);
    chk("done", dn, 1'b1);
    if (!dn)
      finish_test();
    chk("match", mt, exp);
  endtask

  // ****************
  // Sequence
  // ****************
  initial begin
    repeat (16) @(negedge clk_in);
    rst_n_in = 1'b1;
    repeat (3) @(negedge clk_in);
    rdc(ST, 16'hF150);
    rdc(CF, 16'h7800);
    pvs_mgmt_model_i.wr(5'h10, 16'hFFFF);
    rdc(5'h10, 16'h0000);
    pvs_mgmt_model_i.wr(CF, 16'hFFFF);
    rdc(CF, 16'h7800);
    pvs_mgmt_model_i.wr(CF, 16'h83FE);
    rdc(CF, 16'h0000);
    chk("link", {force_link_good_out, link_pulse_enable_out}, 2'h2);
    chk("hb jab sq", {heartbeat_active_out, jabber_active_out, squelch_normal_out}, 3'h0);
    pvs_mgmt_model_i.wr(CF, 16'h7800);
    for (int i = 0; i < 8; i++) begin
      {speed_10_in, full_duplex_in, loopback_in} = i[2:0];
      @(negedge clk_in);
      chk("lp", {force_link_good_out, link_pulse_enable_out}, {1'b0, i[2]});
      chk("hb", heartbeat_active_out, i[2] & ~i[1]);
      chk("jab", jabber_active_out, i[2] & (i[1] | i[0]));
    end
    pvs_mgmt_model_i.wr(ST, 16'hFFFF);
    rdc(ST, 16'hF1F0);
    pvs_mgmt_model_i.wr(ST, 16'h00C0);
    rdc(ST, 16'hF0C0);
    chk("addr", mgmt_station_addr_out, 5'h0C);
    frame(5'h0C, 1'b1);
    frame(5'h06, 1'b0);
    frame(5'h0D, 1'b0);
    an_mode_in = 1'b1;
    for (int i = 0; i < 4; i++) begin
      @(negedge clk_in);
      {an_speed_100_in, an_full_duplex_in} = i[1:0];
      an_complete_in = 1'b1;
      @(negedge clk_in);
      an_complete_in = 1'b0;
      chk("valid", result_valid_out, 1'b1);
      rdc(ST, (16'h1000 << i) | 16'h00C0);
    end
    an_mode_in = 1'b0;
    @(negedge clk_in);
    chk("valid", result_valid_out, 1'b0);
    for (int i = 0; i < 10; i++) begin
      an_monitor_in = i[3:0];
      repeat (2) @(negedge clk_in);
      rdc(ST, 16'h80C0 | (i > 8 ? 16'h8 : i[15:0]));
    end
    polarity_reversed_in = 1'b1;
    repeat (2) @(negedge clk_in);
    rdc(CF, 16'h7801);
    pvs_mgmt_model_i.wr(CF, 16'h7800);
    rdc(CF, 16'h7801);
    polarity_reversed_in = 1'b0;
    repeat (2) @(negedge clk_in);
    rdc(CF, 16'h7800);
    finish_test();
  end
endmodule

`default_nettype wire
